// ===== rtl/rdp_defs.vh
`ifndef RDP_DEFS_VH
`define RDP_DEFS_VH

`define RDP_ADDR_CMD 8'h00
`define RDP_ADDR_CTRL 8'h04
`define RDP_ADDR_STAT 8'h08
`define RDP_CTRL_CLEAR_BIT 0

`define RDP_CMD_RESET 16'h0000
`define RDP_CMD_WMASK 16'hbfff
`define RDP_GA_MASK 16'hbf00
`define RDP_GB_MASK 16'h00f8
`define RDP_GC_MASK 16'h0007

`define RDP_MADDR_CLEAR 12'h00a
`define RDP_MADDR_CTR1 12'h022
`define RDP_MADDR_CTR2 12'h023
`define RDP_MADDR_CTR3 12'h02f

`define RDP_B_Z 8
`define RDP_B_Y 9
`define RDP_B_X 10
`define RDP_B_GYRO 11
`define RDP_B_CONV 12
`define RDP_B_PLUS1 13
`define RDP_B_MINUS1 15
`define RDP_B_ENG 3
`define RDP_B_OPTY 4
`define RDP_B_OPTX 5
`define RDP_B_PLUS2 6
`define RDP_B_MINUS2 7

`define RDP_CLK_HZ 250000000
`define RDP_CLK_MHZ 250
`define RDP_STROBE_HPPS 1024
`define RDP_RATE_HPPS 32
`define RDP_STROBE_US 3

`endif

// ===== rtl/rdp_strobe_gen.v
`timescale 1ns/100ps
`include "rdp_defs.vh"

module rdp_strobe_gen #(
  parameter PERIOD = (`RDP_CLK_HZ / 100) / `RDP_STROBE_HPPS,
  parameter WIDTH = `RDP_CLK_MHZ * `RDP_STROBE_US,
  parameter RATE_DIV = `RDP_STROBE_HPPS / `RDP_RATE_HPPS
) (
  input wire hclk,
  input wire hresetn,
  output reg [2:0] strobe_n_ff,
  output reg rate_gate_n_ff,
  output reg sb0_start_ff,
  output reg rate_start_ff
);

  reg [11:0] cnt_ff;
  reg [5:0] div_ff;
  wire [31:0] last_w = PERIOD - 1;
  wire [31:0] wid_w = WIDTH;
  wire [31:0] off1_w = PERIOD / 3;
  wire [31:0] off2_w = (2 * PERIOD) / 3;
  wire [11:0] last = last_w[11:0];
  wire [11:0] wid = wid_w[11:0];
  wire [11:0] off1 = off1_w[11:0];
  wire [11:0] off2 = off2_w[11:0];
  wire [11:0] d1 = cnt_ff - off1;
  wire [11:0] d2 = cnt_ff - off2;
  wire [2:0] act;
  wire s2_start;

  // Three evenly spaced phases share one period counter.
  assign act[0] = cnt_ff < wid;
  assign act[1] = (cnt_ff >= off1) && (d1 < wid);
  assign act[2] = (cnt_ff >= off2) && (d2 < wid);
  assign s2_start = (cnt_ff == off2);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= 12'h000;
      div_ff <= 6'h00;
      strobe_n_ff <= 3'h7;
      rate_gate_n_ff <= 1'b1;
      sb0_start_ff <= 1'b0;
      rate_start_ff <= 1'b0;
    end else begin
      cnt_ff <= (cnt_ff == last) ? 12'h000 : cnt_ff + 12'h001;
      // Advance at the period wrap so the divider holds across phase two.
      if (cnt_ff == last) begin
        div_ff <= (div_ff == RATE_DIV - 1) ? 6'h00 : div_ff + 6'h01;
      end
      strobe_n_ff <= ~act;
      // Every thirty-second phase-two strobe becomes the gating pulse.
      rate_gate_n_ff <= ~(act[2] && (div_ff == 6'h00));
      sb0_start_ff <= (cnt_ff == 12'h000);
      rate_start_ff <= s2_start && (div_ff == 6'h00);
    end
  end

endmodule

// ===== rtl/rdp_top.v
`timescale 1ns/100ps
`include "rdp_defs.vh"

module rdp_top #(
  parameter PERIOD = (`RDP_CLK_HZ / 100) / `RDP_STROBE_HPPS,
  parameter WIDTH = `RDP_CLK_MHZ * `RDP_STROBE_US
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  input wire computer_restart_signal,
  input wire mem_addr_valid,
  input wire [11:0] mem_addr,
  input wire counter_overflow,
  output reg group_a_clear_line,
  output reg group_b_clear_line,
  output reg group_c_clear_line,
  output wire strobe_phase_zero_n,
  output wire strobe_phase_one_n,
  output wire strobe_phase_two_n,
  output wire rate_gate_n,
  output reg first_counter_plus_request,
  output reg first_counter_minus_request,
  output reg second_counter_plus_request,
  output reg [2:0] gyro_unit_plus,
  output reg [2:0] gyro_unit_minus,
  output reg [2:0] angle_converter_unit_plus,
  output reg [2:0] angle_converter_unit_minus,
  output reg engine_plus,
  output reg engine_minus,
  output reg optics_y_plus,
  output reg optics_y_minus,
  output reg optics_x_plus,
  output reg optics_x_minus
);

  function [1:0] reg_sel;
    input [7:0] a;
    begin
      case (a)
        `RDP_ADDR_CMD: reg_sel = 2'h1;
        `RDP_ADDR_CTRL: reg_sel = 2'h2;
        `RDP_ADDR_STAT: reg_sel = 2'h3;
        default: reg_sel = 2'h0;
      endcase
    end
  endfunction

  reg [15:0] cmd_ff;
  reg [15:0] nxt_cmd;
  reg rate1_ff;
  reg rate2_ff;
  reg restart_s1_ff;
  reg restart_s2_ff;
  reg wr_pend_ff;
  reg rd_pend_ff;
  reg rd_wait_ff;
  reg [7:0] addr_ff;
  reg [7:0] pulses1_ff;
  reg [7:0] pulses2_ff;
  reg [31:0] rd_mux;
  wire [2:0] strobe_n;
  wire sb0_start;
  wire rate_start;
  wire addr_phase;
  wire wr_cmd;
  wire sw_clear;
  wire clr_all;
  wire clr_a;
  wire clr_b;
  wire clr_c;
  wire [2:0] axis;
  wire axis_ok;
  wire gate_active;
  wire go1;
  wire go2;

  rdp_strobe_gen #(
    .PERIOD(PERIOD),
    .WIDTH(WIDTH),
    .RATE_DIV(`RDP_STROBE_HPPS / `RDP_RATE_HPPS)
  ) u_strobe (
    .hclk(hclk),
    .hresetn(hresetn),
    .strobe_n_ff(strobe_n),
    .rate_gate_n_ff(rate_gate_n),
    .sb0_start_ff(sb0_start),
    .rate_start_ff(rate_start)
  );

  assign strobe_phase_zero_n = strobe_n[0];
  assign strobe_phase_one_n = strobe_n[1];
  assign strobe_phase_two_n = strobe_n[2];

  // The restart pin comes from another domain.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      restart_s1_ff <= 1'b0;
      restart_s2_ff <= 1'b0;
    end else begin
      restart_s1_ff <= computer_restart_signal;
      restart_s2_ff <= restart_s1_ff;
    end
  end

  // Bus slave: writes take effect in the data phase; reads add one wait.
  assign addr_phase = hsel && hready && htrans[1];
  assign hreadyout = ~rd_wait_ff;
  assign hresp = 1'b0;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      rd_wait_ff <= 1'b0;
      addr_ff <= 8'h00;
      hrdata <= 32'h00000000;
    end else begin
      if (hready) begin
        wr_pend_ff <= addr_phase && hwrite;
        rd_pend_ff <= addr_phase && !hwrite;
        rd_wait_ff <= addr_phase && !hwrite;
        if (addr_phase) begin
          addr_ff <= haddr[7:0];
        end
      end else begin
        rd_wait_ff <= 1'b0;
      end
      if (rd_wait_ff) begin
        hrdata <= rd_mux;
      end
    end
  end

  always @* begin
    rd_mux = 32'h00000000;
    case (reg_sel(addr_ff))
      2'h1: rd_mux = {16'h0000, cmd_ff};
      2'h3: rd_mux = {13'h0000, pulses2_ff, pulses1_ff, axis_ok,
                      rate2_ff, rate1_ff};
      default: rd_mux = 32'h00000000;
    endcase
  end

  assign wr_cmd = wr_pend_ff && (reg_sel(addr_ff) == 2'h1);
  assign sw_clear = wr_pend_ff && (reg_sel(addr_ff) == 2'h2) &&
                    hwdata[`RDP_CTRL_CLEAR_BIT];

  // Clear decode from program address and counter overflow.
  assign clr_all = sw_clear || restart_s2_ff ||
                   (mem_addr_valid && mem_addr == `RDP_MADDR_CLEAR);
  assign clr_a = clr_all || (mem_addr_valid && counter_overflow &&
                 mem_addr == `RDP_MADDR_CTR1);
  assign clr_b = clr_all || (mem_addr_valid && counter_overflow &&
                 mem_addr == `RDP_MADDR_CTR2);
  assign clr_c = clr_all || (mem_addr_valid && counter_overflow &&
                 mem_addr == `RDP_MADDR_CTR3);

  // A program write in the same cycle as a clear wins, except against a restart clear.
  always @* begin
    nxt_cmd = cmd_ff;
    if (clr_a) begin
      nxt_cmd = nxt_cmd & ~`RDP_GA_MASK;
    end
    if (clr_b) begin
      nxt_cmd = nxt_cmd & ~`RDP_GB_MASK;
    end
    if (clr_c) begin
      nxt_cmd = nxt_cmd & ~`RDP_GC_MASK;
    end
    if (wr_cmd && !restart_s2_ff) begin
      nxt_cmd = hwdata[15:0] & `RDP_CMD_WMASK;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_ff <= `RDP_CMD_RESET;
      group_a_clear_line <= 1'b0;
      group_b_clear_line <= 1'b0;
      group_c_clear_line <= 1'b0;
    end else begin
      cmd_ff <= nxt_cmd;
      group_a_clear_line <= clr_a;
      group_b_clear_line <= clr_b;
      group_c_clear_line <= clr_c;
    end
  end

  // Control flip-flops follow their select bits on each phase-zero strobe.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rate1_ff <= 1'b0;
      rate2_ff <= 1'b0;
    end else if (sb0_start) begin
      rate1_ff <= cmd_ff[`RDP_B_GYRO] | cmd_ff[`RDP_B_CONV];
      rate2_ff <= cmd_ff[`RDP_B_PLUS2] | cmd_ff[`RDP_B_MINUS2];
    end
  end

  assign axis = {cmd_ff[`RDP_B_X], cmd_ff[`RDP_B_Y], cmd_ff[`RDP_B_Z]};
  assign axis_ok = (axis == 3'h4) || (axis == 3'h2) ||
                   (axis == 3'h1);
  assign gate_active = ~rate_gate_n;
  assign go1 = rate1_ff && axis_ok;
  assign go2 = rate2_ff;

  // Drive outputs stand for the gating window; requests are one pulse each.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_counter_plus_request <= 1'b0;
      first_counter_minus_request <= 1'b0;
      second_counter_plus_request <= 1'b0;
      gyro_unit_plus <= 3'h0;
      gyro_unit_minus <= 3'h0;
      angle_converter_unit_plus <= 3'h0;
      angle_converter_unit_minus <= 3'h0;
      engine_plus <= 1'b0;
      engine_minus <= 1'b0;
      optics_y_plus <= 1'b0;
      optics_y_minus <= 1'b0;
      optics_x_plus <= 1'b0;
      optics_x_minus <= 1'b0;
      pulses1_ff <= 8'h00;
      pulses2_ff <= 8'h00;
    end else begin
      first_counter_plus_request <= rate_start && go1 &&
                                    cmd_ff[`RDP_B_PLUS1];
      first_counter_minus_request <= rate_start && go1 &&
                                     cmd_ff[`RDP_B_MINUS1];
      second_counter_plus_request <= rate_start && go2;
      gyro_unit_plus <= (gate_active && go1 && cmd_ff[`RDP_B_GYRO] &&
                         cmd_ff[`RDP_B_PLUS1]) ? axis : 3'h0;
      gyro_unit_minus <= (gate_active && go1 && cmd_ff[`RDP_B_GYRO] &&
                          cmd_ff[`RDP_B_MINUS1]) ? axis : 3'h0;
      angle_converter_unit_plus <= (gate_active && go1 &&
        cmd_ff[`RDP_B_CONV] && cmd_ff[`RDP_B_PLUS1]) ? axis : 3'h0;
      angle_converter_unit_minus <= (gate_active && go1 &&
        cmd_ff[`RDP_B_CONV] && cmd_ff[`RDP_B_MINUS1]) ? axis : 3'h0;
      engine_plus <= gate_active && go2 && cmd_ff[`RDP_B_ENG] &&
                     cmd_ff[`RDP_B_PLUS2];
      engine_minus <= gate_active && go2 && cmd_ff[`RDP_B_ENG] &&
                      cmd_ff[`RDP_B_MINUS2];
      optics_y_plus <= gate_active && go2 && cmd_ff[`RDP_B_OPTY] &&
                       cmd_ff[`RDP_B_PLUS2];
      optics_y_minus <= gate_active && go2 && cmd_ff[`RDP_B_OPTY] &&
                        cmd_ff[`RDP_B_MINUS2];
      optics_x_plus <= gate_active && go2 && cmd_ff[`RDP_B_OPTX] &&
                       cmd_ff[`RDP_B_PLUS2];
      optics_x_minus <= gate_active && go2 && cmd_ff[`RDP_B_OPTX] &&
                        cmd_ff[`RDP_B_MINUS2];
      if (rate_start && go1 &&
          (cmd_ff[`RDP_B_PLUS1] || cmd_ff[`RDP_B_MINUS1])) begin
        pulses1_ff <= pulses1_ff + 8'h01;
      end
      if (rate_start && go2) begin
        pulses2_ff <= pulses2_ff + 8'h01;
      end
    end
  end

endmodule

// ===== sim/rdp_mon_monitor.sv
`timescale 1ns/100ps
module rdp_mon #(
  parameter PERIOD = 30,
  parameter WIDTH = 6
) (
  input wire hclk,
  input wire hresetn,
  input wire mem_addr_valid,
  input wire [11:0] mem_addr,
  input wire counter_overflow,
  input wire group_a_clear_line,
  input wire group_b_clear_line,
  input wire group_c_clear_line,
  input wire strobe_phase_zero_n,
  input wire strobe_phase_two_n,
  input wire rate_gate_n,
  input wire first_counter_plus_request,
  input wire [2:0] gyro_unit_plus,
  input wire engine_plus
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  reg [15:0] lo_ff;
  wire [11:0] ov;
  wire [2:0] gl;
  assign ov = mem_addr_valid && counter_overflow ? mem_addr : 12'hfff;
  assign gl = {group_a_clear_line, group_b_clear_line, group_c_clear_line};
  // Counts the low cycles of phase zero so its width can be judged at the rise.
  always @(posedge hclk or negedge hresetn)
    if (!hresetn) lo_ff <= 16'h0000;
    else lo_ff <= strobe_phase_zero_n ? 16'h0000 : lo_ff + 16'h0001;
  clr_all_a: assert property (mem_addr_valid && mem_addr == 12'h00a
    |=> gl == 3'h7) else $error("clear all missing");
  clr_a_a: assert property (ov == 12'h022 |=> gl == 3'h4)
    else $error("clear a wrong");
  clr_b_a: assert property (ov == 12'h023 |=> gl == 3'h2)
    else $error("clear b wrong");
  clr_c_a: assert property (ov == 12'h02f |=> gl == 3'h1)
    else $error("clear c wrong");
  strobe_w_a: assert property ($rose(strobe_phase_zero_n)
    |-> lo_ff == WIDTH) else $error("strobe width wrong");
  gate_ph_a: assert property (!rate_gate_n |-> !strobe_phase_two_n)
    else $error("gate off phase two");
  req_one_a: assert property (first_counter_plus_request
    |=> !first_counter_plus_request) else $error("request too long");
  drv_gate_a: assert property (|gyro_unit_plus || engine_plus
    |-> !$past(rate_gate_n)) else $error("drive outside gate");
  axis_one_a: assert property ($onehot0(gyro_unit_plus))
    else $error("several axes");
endmodule
bind rdp_top rdp_mon #(.PERIOD(PERIOD), .WIDTH(WIDTH)) u_mon (.hclk,
  .hresetn, .mem_addr_valid, .mem_addr, .counter_overflow,
  .group_a_clear_line, .group_b_clear_line, .group_c_clear_line,
  .strobe_phase_zero_n, .strobe_phase_two_n, .rate_gate_n,
  .first_counter_plus_request, .gyro_unit_plus, .engine_plus);

// ===== sim/rdp_cpc_model.sv
`timescale 1ns/100ps
module rdp_cpc_model (
  input wire hclk,
  input wire hresetn,
  input wire ld,
  input wire req1,
  input wire req2,
  output reg v_ff,
  output reg ovf_ff,
  output reg [11:0] a_ff
);
  // Both counters load zero and overflow on their second request; rate two is served a cycle late.
  localparam [7:0] N = 8'h02;
  reg [7:0] c1_ff, c2_ff;
  reg p2_ff;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {v_ff, ovf_ff, a_ff, c1_ff, c2_ff, p2_ff} <= '0;
    end else begin
      v_ff <= req1 | p2_ff;
      a_ff <= req1 ? 12'h022 : p2_ff ? 12'h023 : ~a_ff;
      ovf_ff <= req1 ? c1_ff + 8'h01 == N :
        p2_ff && c2_ff + 8'h01 == N;
      p2_ff <= req2;
      c1_ff <= ld ? 8'h00 : c1_ff + {7'h00, req1};
      c2_ff <= ld ? 8'h00 : c2_ff + {7'h00, p2_ff};
    end
  end
endmodule

// ===== sim/rate_drive_pulse_control_tb_top.sv
`timescale 1ns/100ps
`include "rdp_defs.vh"
module rate_drive_pulse_control_tb_top;
  localparam int P = 30;
  // Each row is command, expected drive bits, then which rates run.
  logic [39:0] rows [0:6] = '{40'h2c00_20000_2, 40'h9100_00040_2,
    40'h2a95_10004_3, 40'h0048_00020_1, 40'h0060_00002_1,
    40'h0005_00000_0, 40'h2800_00000_0};
  logic [11:0] pa [0:4] = '{12'h022, 12'h02f, 12'h023, 12'h022, 12'h00a};
  logic [15:0] pe [0:4] = '{16'hbfff, 16'hbff8, 16'hbf00, 16'h0, 16'h0};
  logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, rst = 1'b0;
  logic tb_v = 1'b0, tb_o = 1'b0, ld = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [11:0] tb_a = 12'h000;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, r;
  logic [39:0] w;
  logic [19:0] acc;
  logic [15:0] ex;
  wire hreadyout, hresp, m_v, m_o, s0, s1, rg, rp, rm, r2;
  wire ep, em, yp, ym, xp, xm;
  wire [2:0] gp, gm, cp, cm;
  wire [11:0] m_a;
  wire [31:0] hrdata;
  integer bad_count = 0, n_checks = 0, k1, k2;
  longint t0;
  rdp_top #(.PERIOD(P), .WIDTH(6)) i_dut (.hclk, .hresetn, .hsel(1'b1),
    .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .computer_restart_signal(rst), .mem_addr_valid(tb_v | m_v),
    .mem_addr(tb_v ? tb_a : m_a), .counter_overflow(tb_v ? tb_o : m_o),
    .group_a_clear_line(), .group_b_clear_line(), .group_c_clear_line(),
    .strobe_phase_zero_n(s0), .strobe_phase_one_n(s1),
    .strobe_phase_two_n(), .rate_gate_n(rg),
    .first_counter_plus_request(rp), .first_counter_minus_request(rm),
    .second_counter_plus_request(r2), .gyro_unit_plus(gp),
    .gyro_unit_minus(gm), .angle_converter_unit_plus(cp),
    .angle_converter_unit_minus(cm), .engine_plus(ep), .engine_minus(em),
    .optics_y_plus(yp), .optics_y_minus(ym), .optics_x_plus(xp),
    .optics_x_minus(xm));
  rdp_cpc_model i_cpc (.hclk, .hresetn, .ld, .req1(rp | rm), .req2(r2),
    .v_ff(m_v), .ovf_ff(m_o), .a_ff(m_a));
  initial forever #2 hclk = ~hclk;
  always @(negedge hclk) begin
    k1 += rp | rm;
    k2 += r2;
    acc |= {gp, gm, cp, cm, ep, em, yp, ym, xp, xm};
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("FAIL at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic results;
    if (bad_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Entered just after a rising edge; returns just after the last one.
  task automatic xfer(input logic wr, input logic [31:0] a, d);
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    do @(negedge hclk); while (hreadyout !== 1'b1);
    @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    do @(negedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk({31'h0, hresp}, 32'h0);
    @(posedge hclk);
  endtask
  task automatic rd(input logic [31:0] a, e);
    xfer(1'b0, a, 32'h0);
    chk(r, e);
  endtask
  initial begin
    repeat (40000) @(posedge hclk);
    bad_count++;
    results;
  end
  initial begin
    @(negedge hclk);
    chk({29'h0, s0, s1, rg}, 32'h7);
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(`RDP_ADDR_CMD, 32'h0);
    rd(`RDP_ADDR_STAT, 32'h0);
    rd(32'h0c, 32'h0);
    ld <= 1'b1;
    xfer(1'b1, `RDP_ADDR_CMD, 32'hffff);
    rd(`RDP_ADDR_CMD, {16'h0, `RDP_CMD_WMASK});
    xfer(1'b1, `RDP_ADDR_CTRL, 32'h1);
    rd(`RDP_ADDR_CMD, 32'h0);
    for (int j = 0; j < 5; j++) begin
      if (j % 4 == 0) xfer(1'b1, `RDP_ADDR_CMD, 32'hbfff);
      tb_v <= 1'b1;
      tb_a <= pa[j];
      tb_o <= j % 4 != 0;
      @(posedge hclk);
      tb_v <= 1'b0;
      rd(`RDP_ADDR_CMD, {16'h0, pe[j]});
    end
    xfer(1'b1, `RDP_ADDR_CMD, 32'hbfff);
    rst <= 1'b1;
    repeat (4) @(posedge hclk);
    rst <= 1'b0;
    repeat (3) @(posedge hclk);
    rd(`RDP_ADDR_CMD, 32'h0);
    ld <= 1'b0;
    @(negedge s0) t0 = $time;
    @(negedge s1) chk(32'(($time - t0) / 4), P / 3);
    @(negedge s0) chk(32'(($time - t0) / 4), P);
    @(negedge rg) t0 = $time;
    @(posedge rg) chk(32'(($time - t0) / 4), 32'h6);
    @(negedge rg) chk(32'(($time - t0) / 4), 32 * P);
    foreach (rows[i]) begin
      w = rows[i];
      ld <= 1'b1;
      xfer(1'b1, `RDP_ADDR_CMD, {16'h0, w[39:24]});
      ld <= 1'b0;
      k1 = 0;
      k2 = 0;
      acc = '0;
      repeat (96 * P) @(posedge hclk);
      chk(k1, w[1] ? 2 : 0);
      chk(k2, w[0] ? 2 : 0);
      chk({12'h0, acc}, {12'h0, w[23:4]});
      ex = w[39:24] & ~({16{w[1]}} & `RDP_GA_MASK);
      ex = ex & ~({16{w[0]}} & `RDP_GB_MASK);
      rd(`RDP_ADDR_CMD, {16'h0, ex});
    end
    results;
  end
endmodule
